// ===== design/dmatc_transfer_timing.sv
/*
 dmatc_transfer_timing: runs one dma transfer as a source read and a
 destination write, split into bus cycles and timed per region.
 assumes pclk_tick_i is a one-cycle pulse on the core clock marking each
 peripheral bus clock edge, and rdata_i carries the bytes of the current
 bus cycle in its low lanes on the last cycle of that bus cycle.
*/
`timescale 1ns/100ps
// How it works
// - each transfer reads source, then writes destination
// - bus cycles follow addresses and target bus
// - unit crossing a bus slot gets extra cycles
// - 32-bit over 8-bit bus: four byte cycles
// - 32-bit at 4n+1 on 16-bit: three cycles
// - 32-bit at 4n+3 on 16-bit: three cycles
// - each region has own bus width
// - latency counted in region's own clock
// - flash same page two, else three cycles
// - ram write after write, read after write: two
// - back-to-back register accesses add one cycle
// - upper peripheral regions may add one phase cycle
// - total equals read plus write cycles plus one
// - extra cycle decrements the transfer count
// - at least one bus cycle each side
// - source and destination each timed by own region and the access before
module dmatc_transfer_timing #(
   parameter int PAGE_LOG2 = 5,
   parameter int COUNT_W = 16,
   parameter int CYC_W = 8
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // transfer request
   input wire logic req_valid_i,
   input wire dmatc_pkg::dmatc_req_s req_i,
   output logic req_ready_o,
   // peripheral bus clock phase
   input wire logic pclk_tick_i,
   // bus cycles
   output dmatc_pkg::dmatc_bus_s bus_o,
   input wire logic [31:0] rdata_i,
   // completion
   output logic done_o,
   output logic [COUNT_W-1:0] count_o,
   output logic [CYC_W-1:0] cycles_o
);

   // ------------------------------------------------------------
   // parameter check
   // ------------------------------------------------------------
   if (PAGE_LOG2 < 3 || PAGE_LOG2 > 20 || COUNT_W != 16 || CYC_W < 5) begin : g_param_check
      $error("dmatc_transfer_timing: unsupported parameters");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10,
      ST_DEC = 2'b11
   } dmatc_state_e;

   dmatc_state_e state_q;
   logic [31:0] dst_q;
   logic [2:0] unit_bytes_q;
   logic [31:0] cur_addr_q;
   logic [2:0] left_q;
   logic [1:0] off_q;
   logic [31:0] data_q;
   logic [2:0] cnt_q;
   logic aligned_q;
   logic [COUNT_W-1:0] count_q;
   logic [CYC_W-1:0] cyc_q;
   logic [CYC_W-1:0] cycles_q;
   logic done_q;

   // access history for latency rules
   logic hist_valid_q;
   dmatc_pkg::dmatc_kind_e hist_kind_q;
   logic hist_wr_q;
   logic [31:0] hist_addr_q;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [2:0] unit_bytes(dmatc_pkg::dmatc_unit_e u);
      logic [2:0] b;
      b = dmatc_pkg::UNIT8_BYTES;
      unique case (u)
         dmatc_pkg::UNIT_8: b = dmatc_pkg::UNIT8_BYTES;
         dmatc_pkg::UNIT_16: b = dmatc_pkg::UNIT16_BYTES;
         dmatc_pkg::UNIT_32: b = dmatc_pkg::UNIT32_BYTES;
         default: b = dmatc_pkg::UNIT8_BYTES;
      endcase
      return b;
   endfunction

   function automatic logic [31:0] byte_mask(logic [2:0] n);
      logic [31:0] m;
      m = 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         if (3'(i) < n) begin
            m[i*8 +: 8] = 8'hff;
         end
      end
      return m;
   endfunction

   // ------------------------------------------------------------
   // current bus cycle: region, size, latency
   // ------------------------------------------------------------
   dmatc_pkg::dmatc_region_s region;
   logic [2:0] chunk;
   logic last_chunk;
   logic in_bus;
   logic is_write;
   logic [2:0] lat;
   logic unit_tick;
   logic counting;
   logic acc_end;
   logic page_hit;

   assign in_bus = (state_q == ST_READ) || (state_q == ST_WRITE);
   assign is_write = (state_q == ST_WRITE);

   always_comb begin
      region = dmatc_pkg::region_of(cur_addr_q);
   end

   dmatc_split u_split (
      .addr_i(cur_addr_q),
      .left_i(left_q),
      .wlog_i(region.wlog),
      .chunk_o(chunk),
      .last_o(last_chunk)
   );

   assign page_hit = hist_valid_q && (hist_kind_q == dmatc_pkg::RK_FLASH) &&
      ((hist_addr_q >> PAGE_LOG2) == (cur_addr_q >> PAGE_LOG2));

   // access cycles of this bus cycle, in the region's clock
   always_comb begin
      lat = region.acc;
      unique case (region.kind)
         dmatc_pkg::RK_FLASH: begin
            if (page_hit) begin
               lat = dmatc_pkg::FLASH_HIT_ACC;
            end
         end
         dmatc_pkg::RK_RAM: begin
            if (hist_valid_q && hist_kind_q == dmatc_pkg::RK_RAM && hist_wr_q) begin
               lat = dmatc_pkg::RAM_SEQ_ACC;
            end
         end
         dmatc_pkg::RK_SFR: begin
            if (hist_valid_q && hist_kind_q == dmatc_pkg::RK_SFR) begin
               lat = region.acc + dmatc_pkg::SFR_SEQ_ADD;
            end
         end
         dmatc_pkg::RK_NONE: begin
            lat = region.acc;
         end
      endcase
   end

   // regions with pclk set count peripheral clock edges
   assign unit_tick = region.pclk ? pclk_tick_i : 1'b1;
   assign counting = !region.phase || aligned_q;
   assign acc_end = in_bus && unit_tick && counting &&
      (cnt_q == lat - 3'h1);

   // ------------------------------------------------------------
   // bus outputs
   // ------------------------------------------------------------
   always_comb begin
      bus_o.valid = in_bus;
      bus_o.wr = is_write;
      bus_o.addr = cur_addr_q;
      bus_o.nbytes = chunk;
      bus_o.wdata = data_q;
      bus_o.last = acc_end;
   end

   assign req_ready_o = (state_q == ST_IDLE);
   assign done_o = done_q;
   assign count_o = count_q;
   assign cycles_o = cycles_q;

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (req_valid_i) begin
                  state_q <= ST_READ;
               end
            end
            ST_READ: begin
               if (acc_end && last_chunk) begin
                  state_q <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (acc_end && last_chunk) begin
                  state_q <= ST_DEC;
               end
            end
            ST_DEC: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // request capture
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dst_q <= 32'h00000000;
         unit_bytes_q <= dmatc_pkg::UNIT8_BYTES;
      end else if (req_valid_i && req_ready_o) begin
         dst_q <= req_i.dst;
         unit_bytes_q <= unit_bytes(req_i.unit);
      end
   end

   // ------------------------------------------------------------
   // address walk
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cur_addr_q <= 32'h00000000;
         left_q <= 3'h0;
         off_q <= 2'h0;
      end else if (req_valid_i && req_ready_o) begin
         cur_addr_q <= req_i.src;
         left_q <= unit_bytes(req_i.unit);
         off_q <= 2'h0;
      end else if (acc_end) begin
         if (last_chunk && state_q == ST_READ) begin
            cur_addr_q <= dst_q;
            left_q <= unit_bytes_q;
            off_q <= 2'h0;
         end else begin
            cur_addr_q <= cur_addr_q + {29'h0, chunk};
            left_q <= left_q - chunk;
            off_q <= off_q + chunk[1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // access latency counter
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 3'h0;
         aligned_q <= 1'b0;
      end else if (!in_bus || acc_end) begin
         cnt_q <= 3'h0;
         aligned_q <= 1'b0;
      end else if (unit_tick) begin
         if (counting) begin
            cnt_q <= cnt_q + 3'h1;
         end else begin
            aligned_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // data: assemble on read, shift out on write
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         data_q <= 32'h00000000;
      end else if (req_valid_i && req_ready_o) begin
         data_q <= 32'h00000000;
      end else if (acc_end && state_q == ST_READ) begin
         data_q <= data_q | ((rdata_i & byte_mask(chunk)) << {off_q, 3'b000});
      end else if (acc_end && state_q == ST_WRITE) begin
         data_q <= data_q >> {chunk, 3'b000};
      end
   end

   // ------------------------------------------------------------
   // access history
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hist_valid_q <= 1'b0;
         hist_kind_q <= dmatc_pkg::RK_NONE;
         hist_wr_q <= 1'b0;
         hist_addr_q <= 32'h00000000;
      end else if (acc_end) begin
         hist_valid_q <= 1'b1;
         hist_kind_q <= region.kind;
         hist_wr_q <= is_write;
         hist_addr_q <= cur_addr_q;
      end
   end

   // ------------------------------------------------------------
   // cycle count and transfer count
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cyc_q <= '0;
      end else if (req_valid_i && req_ready_o) begin
         cyc_q <= '0;
      end else if (in_bus) begin
         cyc_q <= cyc_q + CYC_W'(1);
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cycles_q <= '0;
      end else if (state_q == ST_DEC) begin
         cycles_q <= cyc_q + CYC_W'(1);
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_q <= '0;
      end else if (req_valid_i && req_ready_o) begin
         count_q <= req_i.count;
      end else if (state_q == ST_DEC) begin
         count_q <= count_q - COUNT_W'(1);
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (state_q == ST_DEC);
      end
   end

endmodule

// ===== design/dmatc_pkg.sv
/*
 dmatc_pkg: shared types, region map and timing constants for the
 dma transfer-cycle sequencer.
 assumes a 32-bit byte address space and one core clock domain.
*/
package dmatc_pkg;

   // ------------------------------------------------------------
   // widths and codes
   // ------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;

   typedef enum logic [1:0] {
      UNIT_8 = 2'h0,
      UNIT_16 = 2'h1,
      UNIT_32 = 2'h2
   } dmatc_unit_e;

   typedef enum logic [1:0] {
      RK_NONE = 2'h0,
      RK_FLASH = 2'h1,
      RK_RAM = 2'h2,
      RK_SFR = 2'h3
   } dmatc_kind_e;

   // ------------------------------------------------------------
   // access timing
   // ------------------------------------------------------------
   localparam logic [2:0] FLASH_HIT_ACC = 3'h2;
   localparam logic [2:0] RAM_SEQ_ACC = 3'h2;
   localparam logic [2:0] SFR_SEQ_ADD = 3'h1;
   localparam logic [2:0] UNIT8_BYTES = 3'h1;
   localparam logic [2:0] UNIT16_BYTES = 3'h2;
   localparam logic [2:0] UNIT32_BYTES = 3'h4;

   // ------------------------------------------------------------
   // region map
   // ------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] lo;
      logic [ADDR_W-1:0] hi;
      dmatc_kind_e kind;
      logic [1:0] wlog;
      logic [2:0] acc;
      logic pclk;
      logic phase;
   } dmatc_region_s;

   localparam int NUM_REGIONS = 13;

   localparam dmatc_region_s REGION_TABLE [NUM_REGIONS] = '{
      '{32'h00000000, 32'h0000001f, RK_SFR, 2'h1, 3'h3, 1'b1, 1'b0},
      '{32'h00000020, 32'h000003ff, RK_SFR, 2'h1, 3'h2, 1'b1, 1'b0},
      '{32'h00000400, 32'h0003ffff, RK_RAM, 2'h3, 3'h1, 1'b0, 1'b0},
      '{32'h00040000, 32'h00041fff, RK_SFR, 2'h1, 3'h2, 1'b1, 1'b0},
      '{32'h00042000, 32'h00043fff, RK_SFR, 2'h2, 3'h2, 1'b1, 1'b0},
      '{32'h00044000, 32'h000440df, RK_SFR, 2'h1, 3'h2, 1'b1, 1'b1},
      '{32'h000440e0, 32'h000443ff, RK_SFR, 2'h1, 3'h3, 1'b1, 1'b1},
      '{32'h00044400, 32'h00045fff, RK_SFR, 2'h1, 3'h2, 1'b1, 1'b1},
      '{32'h00046000, 32'h000467ff, RK_SFR, 2'h2, 3'h3, 1'b1, 1'b1},
      '{32'h00046800, 32'h00047fff, RK_SFR, 2'h2, 3'h2, 1'b1, 1'b1},
      '{32'h00048000, 32'h0004ffff, RK_SFR, 2'h3, 3'h2, 1'b0, 1'b0},
      '{32'h00060000, 32'h00061fff, RK_NONE, 2'h3, 3'h5, 1'b0, 1'b0},
      '{32'hffe00000, 32'hffffffff, RK_FLASH, 2'h3, 3'h3, 1'b0, 1'b0}
   };

   // unmapped space: 64-bit, one core cycle
   localparam dmatc_region_s DEFAULT_REGION =
      '{32'h00000000, 32'h00000000, RK_NONE, 2'h3, 3'h1, 1'b0, 1'b0};

   function automatic dmatc_region_s region_of(logic [ADDR_W-1:0] a);
      dmatc_region_s r;
      r = DEFAULT_REGION;
      for (int i = 0; i < NUM_REGIONS; i++) begin
         if (a >= REGION_TABLE[i].lo && a <= REGION_TABLE[i].hi) begin
            r = REGION_TABLE[i];
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] src;
      logic [ADDR_W-1:0] dst;
      dmatc_unit_e unit;
      logic [15:0] count;
   } dmatc_req_s;

   typedef struct packed {
      logic valid;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [2:0] nbytes;
      logic [DATA_W-1:0] wdata;
      logic last;
   } dmatc_bus_s;

endpackage

// ===== design/dmatc_split.sv
/*
 dmatc_split: sizes one bus cycle of a transfer unit.
 assumes wlog_i gives the bus width as log2 of its byte count.
*/
`timescale 1ns/100ps
module dmatc_split (
   // current position
   input wire logic [31:0] addr_i,
   input wire logic [2:0] left_i,
   input wire logic [1:0] wlog_i,
   // this bus cycle
   output logic [2:0] chunk_o,
   output logic last_o
);

   logic [3:0] width;
   logic [3:0] room;

   // bytes up to the next slot boundary of the target bus
   always_comb begin
      width = 4'h1 << wlog_i;
      room = width - {1'b0, addr_i[2:0] & 3'(width - 4'h1)};
      if ({1'b0, left_i} <= room) begin
         chunk_o = left_i;
      end else begin
         chunk_o = room[2:0];
      end
      last_o = (chunk_o == left_i);
   end

endmodule

// ===== testbench/dmatc_mem_model.sv
/*
 dmatc_mem_model: memory and register buses at the far side.
 assumes read bytes are a fixed pattern of the byte address.
*/
`timescale 1ns/100ps
module dmatc_mem_model (
   // clock
   input wire logic core_clk_i,
   // bus cycles
   input wire dmatc_pkg::dmatc_bus_s bus_i,
   output logic [31:0] rdata_o
);
   logic [31:0] junk_q = 32'h0;
   logic [31:0] pat;
   // ----------------------------------------
   // read bytes, junk outside reads
   // ----------------------------------------
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         pat[8*k +: 8] = 8'(bus_i.addr + 32'(k)) ^ 8'h5a;
      end
   end
   always_ff @(posedge core_clk_i) begin
      junk_q <= ~junk_q;
   end
   assign rdata_o = (bus_i.valid && !bus_i.wr) ? pat : junk_q;
endmodule

// ===== testbench/dmatc_transfer_timing_asserts.sv
/*
 dmatc_transfer_timing_asserts: port checks of the transfer sequencer.
 assumes binding to the top module, one clock domain.
*/
`timescale 1ns/100ps
module dmatc_transfer_timing_asserts #(
   parameter int COUNT_W = 16,
   parameter int CYC_W = 8
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // request
   input wire logic req_valid_i,
   input wire dmatc_pkg::dmatc_req_s req_i,
   input wire logic req_ready_o,
   input wire logic pclk_tick_i,
   // bus and completion
   input wire dmatc_pkg::dmatc_bus_s bus_o,
   input wire logic [31:0] rdata_i,
   input wire logic done_o,
   input wire logic [COUNT_W-1:0] count_o,
   input wire logic [CYC_W-1:0] cycles_o
);
   logic take;
   logic [15:0] cnt_q;
   logic [CYC_W-1:0] span_q;
   logic [CYC_W-1:0] busy_q;
   assign take = req_valid_i && req_ready_o;
   // ----------------------------------------
   // counts since the request was taken
   // ----------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 16'h0;
         span_q <= '0;
         busy_q <= '0;
      end else if (take) begin
         cnt_q <= req_i.count;
         span_q <= CYC_W'(1);
         busy_q <= '0;
      end else begin
         span_q <= span_q + CYC_W'(1);
         busy_q <= busy_q + CYC_W'(bus_o.valid);
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_busy_after_take: assert property (take |=> !req_ready_o)
      else $error("still ready after a take");
   a_read_first: assert property (take |=> bus_o.valid && !bus_o.wr)
      else $error("transfer did not open with a read");
   a_no_late_read: assert property (bus_o.valid && bus_o.wr |=> !(bus_o.valid && !bus_o.wr))
      else $error("read after write in one transfer");
   a_cycle_nonempty: assert property (bus_o.valid |-> bus_o.nbytes != 3'h0)
      else $error("bus cycle without bytes");
   a_cycle_stable: assert property (bus_o.valid && !bus_o.last |=> bus_o.valid
      && $stable(bus_o.addr) && $stable(bus_o.nbytes) && $stable(bus_o.wr))
      else $error("bus cycle changed before its end");
   a_ascend_addr: assert property ((bus_o.valid && bus_o.last) ##1
      (bus_o.valid && bus_o.wr == $past(bus_o.wr))
      |-> bus_o.addr == $past(bus_o.addr) + 32'($past(bus_o.nbytes)))
      else $error("split cycles not in ascending order");
   a_slot_narrow: assert property (bus_o.valid && bus_o.addr < 32'h400
      |-> 3'(bus_o.addr[0]) + bus_o.nbytes <= 3'h2)
      else $error("16-bit slot crossed");
   a_dec_cycle: assert property ((bus_o.valid && bus_o.wr && bus_o.last) ##1
      !bus_o.valid |=> done_o)
      else $error("no completion after the decrement cycle");
   a_count_dec: assert property (done_o |-> count_o == COUNT_W'(cnt_q - 16'h1))
      else $error("count not decremented by one");
   a_total_cycles: assert property (done_o |-> cycles_o == busy_q + CYC_W'(1)
      && span_q == cycles_o + CYC_W'(1))
      else $error("cycle total wrong");
endmodule

// ===== testbench/dmatc_transfer_timing_bench.sv
/*
 dmatc_transfer_timing_bench: drives transfers, checks bus cycles and totals.
 assumes the memory model pattern for read data.
*/
`timescale 1ns/100ps
module dmatc_transfer_timing_bench;
   typedef struct packed {
      logic wr;
      logic [31:0] addr;
      logic [2:0] nb;
      logic [31:0] data;
   } dmatc_exp_s;
   typedef struct {int lo; int hi; logic [15:0] cnt;} dmatc_res_s;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic req_valid_i = 1'b0;
   dmatc_pkg::dmatc_req_s req_i = '0;
   logic req_ready_o;
   logic pclk_tick_i = 1'b0;
   dmatc_pkg::dmatc_bus_s bus_o;
   logic [31:0] rdata_i;
   logic done_o;
   logic [15:0] count_o;
   logic [7:0] cycles_o;
   int seed = 32'hd741;
   int n_errors = 0;
   int total_checks = 0;
   logic tick_mode = 1'b0;
   dmatc_exp_s bq[$];
   dmatc_res_s rq[$];

   always #4 core_clk_i = ~core_clk_i;

   dmatc_transfer_timing u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
      .pclk_tick_i(pclk_tick_i), .bus_o(bus_o), .rdata_i(rdata_i),
      .done_o(done_o), .count_o(count_o), .cycles_o(cycles_o));
   dmatc_mem_model u_mem (.core_clk_i(core_clk_i), .bus_i(bus_o), .rdata_o(rdata_i));

   always @(posedge core_clk_i) begin
      #1;
      pclk_tick_i = tick_mode ? ~pclk_tick_i : 1'($random(seed));
   end
   // ----------------------------------------
   // expectations
   // ----------------------------------------
   function automatic int bw(input logic [31:0] a);
      return (a < 32'h400) ? 2 : ((a >= 32'h40000 && a < 32'h48000) ? (a[13] ? 4 : 2) : 8);
   endfunction

   function automatic int split(input logic [31:0] a, input int n, input logic wr,
                                input logic [31:0] s);
      int o;
      int c;
      int w;
      int cnt;
      dmatc_exp_s e;
      o = 0;
      cnt = 0;
      while (o < n) begin
         w = bw(a + 32'(o));
         c = w - int'((a + 32'(o)) & 32'(w - 1));
         if (c > n - o) c = n - o;
         e = '0;
         e.wr = wr;
         e.addr = a + 32'(o);
         e.nb = 3'(c);
         for (int k = 0; k < c; k++) e.data[8*k +: 8] = 8'(s + 32'(o + k)) ^ 8'h5a;
         bq.push_back(e);
         o += c;
         cnt++;
      end
      return cnt;
   endfunction

   task automatic err(input string m);
      n_errors++;
      $display("Error at %0t: %s", $time, m);
   endtask

   task automatic xfer(input logic [31:0] s, d, input dmatc_pkg::dmatc_unit_e u,
                       input int lo, hi);
      int n;
      int rn;
      int wn;
      int i;
      dmatc_res_s r;
      n = (u == dmatc_pkg::UNIT_8) ? 1 : ((u == dmatc_pkg::UNIT_16) ? 2 : 4);
      r.cnt = 16'($random(seed));
      rn = split(s, n, 1'b0, s);
      wn = split(d, n, 1'b1, s);
      r.lo = (lo == 0) ? rn + 2 * wn + 1 : lo;
      r.hi = (lo == 0) ? r.lo : hi;
      req_valid_i = 1'b1;
      req_i = '{src: s, dst: d, unit: u, count: r.cnt};
      r.cnt = r.cnt - 16'h1;
      rq.push_back(r);
      i = 0;
      while (req_ready_o !== 1'b1 && i < 100) begin
         @(posedge core_clk_i);
         #1;
         i++;
      end
      @(posedge core_clk_i);
      #1;
      if (i >= 100) err("request never taken");
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // monitor
   // ----------------------------------------
   always @(negedge core_clk_i) begin
      dmatc_exp_s e;
      dmatc_res_s r;
      logic [31:0] m;
      logic ok;
      if (rst_i === 1'b0 && bus_o.valid === 1'b1 && bus_o.last === 1'b1) begin
         total_checks++;
         if (bq.size() == 0) err("unexpected bus cycle");
         else begin
            e = bq.pop_front();
            m = (32'h1 << (8 * e.nb)) - 32'h1;
            if (bus_o.wr !== e.wr || bus_o.addr !== e.addr || bus_o.nbytes !== e.nb
               || (e.wr && ((bus_o.wdata & m) !== (e.data & m)))) err("bus cycle mismatch");
         end
      end
      if (rst_i === 1'b0 && done_o === 1'b1) begin
         total_checks++;
         if (rq.size() == 0) err("unexpected completion");
         else begin
            r = rq.pop_front();
            ok = cycles_o >= 8'(r.lo) && cycles_o <= 8'(r.hi) && count_o === r.cnt;
            if (ok !== 1'b1) err("transfer result mismatch");
         end
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge core_clk_i);
      #1;
      rst_i = 1'b0;
      xfer(32'h400, 32'h800, dmatc_pkg::UNIT_32, 3, 3);
      xfer(32'h400, 32'h800, dmatc_pkg::UNIT_32, 4, 4);
      xfer(32'h405, 32'h80d, dmatc_pkg::UNIT_32, 7, 7);
      xfer(32'h410, 32'h411, dmatc_pkg::UNIT_8, 4, 4);
      xfer(32'h60000, 32'h420, dmatc_pkg::UNIT_16, 7, 7);
      xfer(32'hffe00006, 32'h430, dmatc_pkg::UNIT_32, 7, 7);
      xfer(32'hffe0001e, 32'h438, dmatc_pkg::UNIT_32, 8, 8);
      xfer(32'h70000, 32'h440, dmatc_pkg::UNIT_32, 3, 3);
      tick_mode = 1'b1;
      xfer(32'h380, 32'h3c0, dmatc_pkg::UNIT_16, 9, 11);
      xfer(32'h21, 32'h800, dmatc_pkg::UNIT_32, 17, 20);
      xfer(32'h23, 32'h804, dmatc_pkg::UNIT_32, 15, 18);
      xfer(32'h42002, 32'h808, dmatc_pkg::UNIT_32, 10, 12);
      xfer(32'h44000, 32'h80c, dmatc_pkg::UNIT_16, 6, 8);
      xfer(32'h400, 32'h800, dmatc_pkg::UNIT_32, 4, 4);
      tick_mode = 1'b0;
      for (int i = 0; i < 8; i++) begin
         xfer(32'h1000 | (32'($random(seed)) & 32'hff),
              32'h1800 | (32'($random(seed)) & 32'hff),
              dmatc_pkg::dmatc_unit_e'(2'($unsigned($random(seed)) % 3)), 0, 0);
      end
      req_valid_i = 1'b0;
      for (int i = 0; i < 200 && (bq.size() != 0 || rq.size() != 0); i++) begin
         @(posedge core_clk_i);
      end
      if (bq.size() != 0 || rq.size() != 0) err("transfers left unfinished");
      print_verdict();
   end

   initial begin
      #50000;
      n_errors++;
      print_verdict();
   end
endmodule

bind dmatc_transfer_timing dmatc_transfer_timing_asserts #(.COUNT_W(COUNT_W), .CYC_W(CYC_W))
   u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
   .req_i(req_i), .req_ready_o(req_ready_o), .pclk_tick_i(pclk_tick_i), .bus_o(bus_o),
   .rdata_i(rdata_i), .done_o(done_o), .count_o(count_o), .cycles_o(cycles_o));
